/* File: src/ssm_pkg.sv */
package ssm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SDATA = 8'h04;
    localparam logic [7:0] OFS_PRESC = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    // Control word, upper byte
    localparam int SEL_LSB = 13;
    localparam int IE_BIT = 12;
    localparam int FLAG_BIT = 11;
    localparam int BUSY_BIT = 10;
    localparam int STOP_BIT = 9;
    localparam int START_BIT = 8;
    // Control word, lower byte
    localparam int MODE_BIT = 3;
    localparam int BDS_BIT = 2;
    localparam int SOE_BIT = 1;
    localparam int SHIFT_CLOCK_OUT_EN_BIT = 0;
    // Prescaler word
    localparam int MD_BIT = 7;
    localparam int DIV_LSB = 0;
    // Event status bits
    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_W = 2;
    // Shift clock select codes
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] SEL_EXT = 3'h5;
    // Half periods of the shift clock in prescaled clocks, per code
    localparam logic [5:0] HALF_0 = 6'h01;
    localparam logic [5:0] HALF_1 = 6'h02;
    localparam logic [5:0] HALF_2 = 6'h08;
    localparam logic [5:0] HALF_3 = 6'h10;
    localparam logic [5:0] HALF_4 = 6'h20;
    localparam logic [3:0] XFER_BITS = 4'h8;
    localparam logic [7:0] PRESC_RESET = 8'h00;
    typedef enum logic [1:0] {ST_STOPPED, ST_WAIT, ST_SHIFT} ssm_state_type;
endpackage

/* File: src/ssm_clk_if.sv */
interface ssm_clk_if;
    logic run;
    logic md;
    logic [2:0] div;
    logic [2:0] sel;
    logic tick;
    modport gen (input run, input md, input div, input sel, output tick);
    modport user (output run, output md, output div, output sel, input tick);
endinterface

/* File: src/ssm_clkgen.sv */
// Internal shift clock: machine clock / (div + 1), then / code ratio
module ssm_clkgen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Rate control and tick
    ssm_clk_if.gen ck
);
    typedef struct packed {
        logic [2:0] pre;
        logic [5:0] half;
    } ssm_cg_type;
    ssm_cg_type s_q, s_d;
    logic pre_tick;
    logic [5:0] half_lim;

    // Half-period length per select code
    always_comb begin
        unique case (ck.sel)
            3'h0: half_lim = ssm_pkg::HALF_0;
            3'h1: half_lim = ssm_pkg::HALF_1;
            3'h2: half_lim = ssm_pkg::HALF_2;
            3'h3: half_lim = ssm_pkg::HALF_3;
            default: half_lim = ssm_pkg::HALF_4;
        endcase
    end

    // Both dividers run only during an internal-clock transfer
    always_comb begin
        s_d = s_q;
        pre_tick = 1'b0;
        ck.tick = 1'b0;
        if (!ck.run || !ck.md) begin
            s_d = '0;
        end else if (s_q.pre == ck.div) begin
            s_d.pre = '0;
            pre_tick = 1'b1;
        end else begin
            s_d.pre = s_q.pre + 3'h1;
        end
        if (pre_tick) begin
            if (s_q.half == half_lim - 6'h01) begin
                s_d.half = '0;
                ck.tick = 1'b1;
            end else begin
                s_d.half = s_q.half + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* File: src/ssm_top.sv */
// Function
// - Three-bit clock select picks five internal rates or external; resets 000.
// - Internal rate depends on select code and prescaler division ratio.
// - Transfer interrupt request (xfer_irq) only while enable is 1 and flag set; enable resets 0.
// - Flag sets whenever a serial transfer ends.
// - With start-condition bit 0, writing 0 clears the flag.
// - With start-condition bit 1, any shift data access clears the flag.
// - Reset or writing stop 1 clears the flag, unless a transfer ends in the same cycle.
// - Writing 1 to the flag changes nothing.
// - Busy reads 1 only while a transfer runs; resets 0.
// - Stop write 1 aborts transfer and holds stopped; stop resets 1.
// - Start write 1 while stopped begins a transfer.
// - Start 1 ignored when busy or waiting; start reads 0.
// - External clock, output disabled: shift on each rising edge of the port pin, next output bit on each falling edge.
// - Start-condition bit picks start command or data access to resume.
// - Clock output enable hands clock pin between port and serial use.
module ssm_top (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupts
    output logic xfer_irq,
    output logic irq,
    // Shift clock pin
    input wire logic sc_in,
    output logic sc_out,
    output logic sc_oe_n,
    // General port drive of the clock pin
    input wire logic port_sc_data,
    input wire logic port_sc_dir,
    // Serial data pins
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_n
);
    typedef struct packed {
        ssm_pkg::ssm_state_type st;
        logic [2:0] sel;
        logic ie;
        logic flag;
        logic stop;
        logic mode;
        logic bds;
        logic soe;
        logic shift_clock_out_en;
        logic [7:0] presc;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic sck;
        logic so;
        logic [2:0] sync;
        logic ext_lvl;
        logic [ssm_pkg::EV_W-1:0] ev;
        logic [ssm_pkg::EV_W-1:0] mask;
    } ssm_regs_type;
    ssm_regs_type r_q, r_d;
    ssm_clk_if ck ();
    logic acc, wr, rd, hit;
    logic wr_ctrl_hi, wr_ctrl_lo, sd_acc, ext_mode;
    logic rise, fall, done, abort;
    logic start_req, sd_start;
    logic [ssm_pkg::EV_W-1:0] ev_set;

    ssm_clkgen u_clkgen (
        .pclk(pclk),
        .presetn(presetn),
        .ck(ck)
    );

    // Bus decode, zero wait states
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign hit = (paddr == ssm_pkg::OFS_CTRL) ||
                 (paddr == ssm_pkg::OFS_SDATA) ||
                 (paddr == ssm_pkg::OFS_PRESC) ||
                 (paddr == ssm_pkg::OFS_IRQ_STAT) ||
                 (paddr == ssm_pkg::OFS_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign wr_ctrl_hi = wr & pstrb[1] & (paddr == ssm_pkg::OFS_CTRL);
    assign wr_ctrl_lo = wr & pstrb[0] & (paddr == ssm_pkg::OFS_CTRL);
    assign sd_acc = acc & (paddr == ssm_pkg::OFS_SDATA);
    assign ext_mode = (r_q.sel == ssm_pkg::SEL_EXT);

    // Rate control to the shift clock generator
    // code and prescaler
    assign ck.run = (r_q.st == ssm_pkg::ST_SHIFT) & ~ext_mode;
    assign ck.md = r_q.presc[ssm_pkg::MD_BIT];
    assign ck.div = r_q.presc[ssm_pkg::DIV_LSB +: 3];
    assign ck.sel = r_q.sel;

    // Clock edges: internal ticks or filtered pin edges
    // pin edges shift
    always_comb begin
        if (ext_mode) begin
            rise = (r_q.sync[1] == r_q.sync[2]) & r_q.sync[2] & ~r_q.ext_lvl;
            fall = (r_q.sync[1] == r_q.sync[2]) & ~r_q.sync[2] & r_q.ext_lvl;
        end else begin
            rise = ck.tick & ~r_q.sck;
            fall = ck.tick & r_q.sck;
        end
    end

    // Start conditions and transfer end
    // start source
    assign start_req = wr_ctrl_hi & pwdata[ssm_pkg::START_BIT] &
                       ~pwdata[ssm_pkg::STOP_BIT];
    assign sd_start = sd_acc & r_q.mode & ~r_q.stop;
    assign done = (r_q.st == ssm_pkg::ST_SHIFT) & rise &
                  (r_q.cnt == ssm_pkg::XFER_BITS - 4'h1);
    assign abort = wr_ctrl_hi & pwdata[ssm_pkg::STOP_BIT] &
                   (r_q.st == ssm_pkg::ST_SHIFT);
    assign ev_set = {abort, done};

    // All register and transfer state
    always_comb begin
        r_d = r_q;
        r_d.sync = {r_q.sync[1:0], sc_in};
        if (r_q.sync[1] == r_q.sync[2]) begin
            r_d.ext_lvl = r_q.sync[2];
        end
        if (wr_ctrl_hi) begin
            r_d.sel = pwdata[ssm_pkg::SEL_LSB +: 3];
            r_d.ie = pwdata[ssm_pkg::IE_BIT];
        end
        if (wr_ctrl_lo) begin
            r_d.mode = pwdata[ssm_pkg::MODE_BIT];
            r_d.bds = pwdata[ssm_pkg::BDS_BIT];
            r_d.soe = pwdata[ssm_pkg::SOE_BIT];
            r_d.shift_clock_out_en = pwdata[ssm_pkg::SHIFT_CLOCK_OUT_EN_BIT];
        end
        if (wr && paddr == ssm_pkg::OFS_PRESC && pstrb[0]) begin
            r_d.presc = pwdata[7:0];
        end
        if (wr && paddr == ssm_pkg::OFS_IRQ_MASK && pstrb[0]) begin
            r_d.mask = pwdata[ssm_pkg::EV_W-1:0];
        end
        // Shift data writes only outside a transfer
        if (wr && paddr == ssm_pkg::OFS_SDATA && pstrb[0] &&
            r_q.st != ssm_pkg::ST_SHIFT) begin
            r_d.sr = pwdata[7:0];
        end
        if (wr_ctrl_hi && !r_q.mode && !pwdata[ssm_pkg::FLAG_BIT]) begin
            r_d.flag = 1'b0;
        end
        if (sd_acc && r_q.mode) begin
            r_d.flag = 1'b0;
        end
        // Transfer sequencing
        unique case (r_q.st)
            ssm_pkg::ST_STOPPED: begin
                if (start_req || sd_start) begin
                    r_d.st = ssm_pkg::ST_SHIFT;
                    r_d.stop = 1'b0;
                    r_d.cnt = '0;
                end
            end
            ssm_pkg::ST_WAIT: begin
                if (sd_start) begin
                    r_d.st = ssm_pkg::ST_SHIFT;
                    r_d.cnt = '0;
                end
            end
            ssm_pkg::ST_SHIFT: begin
                if (fall) begin
                    r_d.so = r_q.bds ? r_q.sr[7] : r_q.sr[0];
                end
                if (rise) begin
                    r_d.sr = r_q.bds ? {r_q.sr[6:0], si_in}
                                     : {si_in, r_q.sr[7:1]};
                    r_d.cnt = r_q.cnt + 4'h1;
                end
                if (ck.tick) begin
                    r_d.sck = ~r_q.sck;
                end
                if (done) begin
                    r_d.st = r_q.mode ? ssm_pkg::ST_WAIT
                                      : ssm_pkg::ST_STOPPED;
                end
            end
        endcase
        if (wr_ctrl_hi && !pwdata[ssm_pkg::STOP_BIT] &&
            r_q.st == ssm_pkg::ST_STOPPED && !start_req) begin
            r_d.stop = 1'b0;
        end
        if (wr_ctrl_hi && pwdata[ssm_pkg::STOP_BIT]) begin
            r_d.stop = 1'b1;
            r_d.st = ssm_pkg::ST_STOPPED;
            r_d.sck = 1'b1;
            r_d.flag = 1'b0;
        end
        if (done) begin
            r_d.flag = 1'b1;
        end
        // Sticky events, write one to clear, set wins
        if (wr && paddr == ssm_pkg::OFS_IRQ_STAT && pstrb[0]) begin
            r_d.ev = r_q.ev & ~pwdata[ssm_pkg::EV_W-1:0];
        end
        r_d.ev = r_d.ev | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
            r_q.st <= ssm_pkg::ST_STOPPED;
            r_q.sel <= ssm_pkg::SEL_RESET;
            r_q.stop <= 1'b1;
            r_q.presc <= ssm_pkg::PRESC_RESET;
            r_q.sck <= 1'b1;
            // Pin idles high, so no false edge follows reset
            r_q.sync <= '1;
            r_q.ext_lvl <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Read mux, start bit reads 0
    // busy readback
    always_comb begin
        prdata = '0;
        if (rd) begin
            unique case (paddr)
                ssm_pkg::OFS_CTRL: begin
                    prdata[ssm_pkg::SEL_LSB +: 3] = r_q.sel;
                    prdata[ssm_pkg::IE_BIT] = r_q.ie;
                    prdata[ssm_pkg::FLAG_BIT] = r_q.flag;
                    prdata[ssm_pkg::BUSY_BIT] = r_q.st == ssm_pkg::ST_SHIFT;
                    prdata[ssm_pkg::STOP_BIT] = r_q.stop;
                    prdata[ssm_pkg::MODE_BIT] = r_q.mode;
                    prdata[ssm_pkg::BDS_BIT] = r_q.bds;
                    prdata[ssm_pkg::SOE_BIT] = r_q.soe;
                    prdata[ssm_pkg::SHIFT_CLOCK_OUT_EN_BIT] = r_q.shift_clock_out_en;
                end
                ssm_pkg::OFS_SDATA: prdata[7:0] = r_q.sr;
                ssm_pkg::OFS_PRESC: prdata[7:0] = r_q.presc;
                ssm_pkg::OFS_IRQ_STAT: prdata[ssm_pkg::EV_W-1:0] = r_q.ev;
                ssm_pkg::OFS_IRQ_MASK: prdata[ssm_pkg::EV_W-1:0] = r_q.mask;
                default: prdata = '0;
            endcase
        end
    end

    // Pins and interrupts
    // level request
    assign xfer_irq = r_q.flag & r_q.ie;
    assign irq = |(r_q.ev & r_q.mask);
    assign sc_out = r_q.shift_clock_out_en ? r_q.sck : port_sc_data;
    assign sc_oe_n = r_q.shift_clock_out_en ? ext_mode : ~port_sc_dir;
    assign so_out = r_q.so;
    assign so_oe_n = ~r_q.soe;

    property p_stop_clr;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl_hi && pwdata[ssm_pkg::STOP_BIT] && !done |=>
            r_q.stop && !r_q.flag && r_q.st == ssm_pkg::ST_STOPPED;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop failed");
    property p_done_set;
        @(posedge pclk) disable iff (!presetn)
        done |=> r_q.flag ##0 r_q.st != ssm_pkg::ST_SHIFT;
    endproperty
    a_done_set: assert property (p_done_set) else $error("no flag");
    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        $rose(r_q.flag) && r_q.ie |-> xfer_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_irq_hold;
        @(posedge pclk) disable iff (!presetn)
        r_q.flag && !wr_ctrl_hi && !sd_acc |=> r_q.flag;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq glitch");
    property p_start;
        @(posedge pclk) disable iff (!presetn)
        start_req && r_q.st == ssm_pkg::ST_STOPPED |=>
            r_q.st == ssm_pkg::ST_SHIFT && r_q.cnt == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_wait_ign;
        @(posedge pclk) disable iff (!presetn)
        r_q.st == ssm_pkg::ST_WAIT && start_req && !sd_acc |=>
            r_q.st == ssm_pkg::ST_WAIT;
    endproperty
    a_wait_ign: assert property (p_wait_ign) else $error("start taken");
    property p_clr0;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl_hi && !r_q.mode && !pwdata[ssm_pkg::FLAG_BIT] && !done
            |=> !r_q.flag;
    endproperty
    a_clr0: assert property (p_clr0) else $error("flag kept");
    property p_sd_clr;
        @(posedge pclk) disable iff (!presetn)
        sd_acc && r_q.mode && !done |=> !r_q.flag;
    endproperty
    a_sd_clr: assert property (p_sd_clr) else $error("flag kept");
    property p_w1;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl_hi && pwdata[ssm_pkg::FLAG_BIT] &&
            !pwdata[ssm_pkg::STOP_BIT] && r_q.flag |=> r_q.flag;
    endproperty
    a_w1: assert property (p_w1) else $error("flag lost");
    property p_ext;
        @(posedge pclk) disable iff (!presetn)
        ext_mode && r_q.st == ssm_pkg::ST_SHIFT && rise && !wr_ctrl_hi
            |=> r_q.cnt == $past(r_q.cnt) + 4'h1 || r_q.st != $past(r_q.st);
    endproperty
    a_ext: assert property (p_ext) else $error("no ext shift");
    c_done: cover property (@(posedge pclk) disable iff (!presetn) done);
    c_resume: cover property (@(posedge pclk) disable iff (!presetn)
        r_q.st == ssm_pkg::ST_WAIT && sd_start);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) abort);
endmodule

/* File: verif/ssm_peer.sv */
// Far-side serial partner: clock-synchronous peer on the shared pins
module ssm_peer (
    // Pin levels seen by the peer
    input wire logic sck,
    input wire logic sdo,
    // Byte to send and byte received
    input wire logic [7:0] tx,
    output logic sdi,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idx_q;
    // Idle state before any frame
    initial begin
        sdi = 1'b1;
        idx_q = 3'h0;
        rx = 8'h00;
    end
    // Next bit presented on each falling edge, lsb first
    always @(negedge sck) begin
        sdi <= tx[idx_q];
        idx_q <= idx_q + 3'h1;
    end
    // Device output captured on each rising edge
    always @(posedge sck) begin
        rx <= {sdo, rx[7:1]};
    end
endmodule

/* File: verif/test_sync_serial_mode_control.sv */
module test_sync_serial_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, xfer_irq, irq, sc_out, sc_oe_n, so_out, so_oe_n;
    logic port_sc_data = 1'b1;
    logic port_sc_dir = 1'b0;
    logic si_in, sc_pin;
    logic [7:0] peer_tx = 8'h3c;
    logic [7:0] peer_rx;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc_count = 0;
    // Clock pin has a pull-up when nobody drives it
    assign sc_pin = sc_oe_n ? 1'b1 : sc_out;
    always #10 pclk = ~pclk;
    ssm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xfer_irq(xfer_irq), .irq(irq), .sc_in(sc_pin), .sc_out(sc_out),
        .sc_oe_n(sc_oe_n), .port_sc_data(port_sc_data),
        .port_sc_dir(port_sc_dir), .si_in(si_in), .so_out(so_out),
        .so_oe_n(so_oe_n));
    ssm_peer u_peer (.sck(sc_pin), .sdo(so_oe_n ? 1'b1 : so_out),
        .tx(peer_tx), .sdi(si_in), .rx(peer_rx));
    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc_count++;
        if (cyc_count > 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc;
        apb(ssm_pkg::OFS_CTRL, 1'b0, 32'h0);
    endtask
    // Control word: flag field, soe always on
    function automatic logic [31:0] ctl(input logic [2:0] s,
        input logic ie, fl, stp, st, md, shift_clock_out_en);
        return {16'h0, s, ie, fl, 1'b0, stp, st, 4'h0, md, 2'b01, shift_clock_out_en};
    endfunction
    // Poll until the busy bit drops
    // shift data touched only once idle
    task automatic wait_idle;
        int n;
        n = 0;
        rc();
        while (rd[10] !== 1'b0 && n < 3000) begin
            rc();
            n++;
        end
        chk("idle", {31'h0, rd[10]}, 32'h0);
    endtask
    task automatic t_reset;
        rc();
        chk("ctrl_rst", {24'h0, rd[15:8]}, 32'h02);
        chk("irqs_rst", {30'h0, xfer_irq, irq}, 32'h0);
    endtask
    task automatic t_rate;
        logic [5:0] hv [5];
        time t0;
        int lo, cyc;
        hv = '{ssm_pkg::HALF_0, ssm_pkg::HALF_1, ssm_pkg::HALF_2,
            ssm_pkg::HALF_3, ssm_pkg::HALF_4};
        apb(ssm_pkg::OFS_PRESC, 1'b1, 32'h81);
        // only codes 0 to 4 are used here
        for (int c = 0; c < 5; c++) begin
            peer_tx = 8'hc3 ^ 8'(c);
            apb(ssm_pkg::OFS_SDATA, 1'b1, 32'h5a + c);
            t0 = $time;
            apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(3'(c), 0, 0, 0, 1, 0, 1));
            rc();
            chk("busy", {31'h0, rd[10]}, 32'h1);
            wait_idle();
            cyc = int'(($time - t0) / 20);
            lo = 32 * int'(hv[c]);
            chk("rate", {31'h0, cyc >= lo && cyc <= lo + 24}, 32'h1);
            rc();
            chk("flag", {31'h0, rd[11]}, 32'h1);
            chk("irq_off", {31'h0, xfer_irq}, 32'h0);
            chk("peer_rx", {24'h0, peer_rx}, 32'h5a + c);
            apb(ssm_pkg::OFS_SDATA, 1'b0, 32'h0);
            chk("sd_rx", {24'h0, rd[7:0]}, {24'h0, peer_tx});
        end
        // Msb first: both bytes arrive bit-reversed at the lsb-first peer
        peer_tx = 8'h03;
        apb(ssm_pkg::OFS_SDATA, 1'b1, 32'h01);
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(0, 0, 0, 0, 1, 0, 1) | 32'h4);
        wait_idle();
        apb(ssm_pkg::OFS_SDATA, 1'b0, 32'h0);
        chk("msb_rx", {24'h0, rd[7:0]}, 32'hc0);
        chk("msb_tx", {24'h0, peer_rx}, 32'h80);
    endtask
    task automatic t_irq;
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(4, 1, 1, 0, 0, 0, 1));
        rc();
        chk("flag_w1", {31'h0, rd[11]}, 32'h1);
        chk("xirq_on", {31'h0, xfer_irq}, 32'h1);
        chk("irq_mask", {31'h0, irq}, 32'h0);
        apb(ssm_pkg::OFS_IRQ_MASK, 1'b1, 32'h1);
        // Let the write settle before looking at the pin
        @(negedge pclk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(ssm_pkg::OFS_IRQ_STAT, 1'b1, 32'h1);
        @(negedge pclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(4, 1, 0, 0, 0, 0, 1));
        rc();
        chk("flag_w0", {31'h0, rd[11]}, 32'h0);
        chk("xirq_off", {31'h0, xfer_irq}, 32'h0);
    endtask
    task automatic t_mode1;
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(0, 0, 0, 0, 1, 1, 1));
        wait_idle();
        rc();
        chk("m1_flag", {31'h0, rd[11]}, 32'h1);
        apb(ssm_pkg::OFS_SDATA, 1'b0, 32'h0);
        rc();
        chk("m1_resume", {30'h0, rd[11:10]}, 32'h1);
        wait_idle();
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(0, 0, 1, 1, 0, 1, 1));
        rc();
        chk("stop_clr", {29'h0, rd[11:9]}, 32'h1);
    endtask
    task automatic t_ext;
        port_sc_dir <= 1'b1;
        peer_tx = 8'h96;
        apb(ssm_pkg::OFS_SDATA, 1'b1, 32'h69);
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(5, 0, 0, 0, 1, 0, 0));
        rc();
        chk("ext_busy", {31'h0, rd[10]}, 32'h1);
        chk("port_pin", {30'h0, sc_oe_n, sc_out}, 32'h1);
        // Port toggles stand in for CPU-made shift edges
        repeat (16) begin
            repeat (8) @(posedge pclk);
            port_sc_data <= ~port_sc_data;
        end
        wait_idle();
        apb(ssm_pkg::OFS_SDATA, 1'b0, 32'h0);
        chk("ext_rx", {24'h0, rd[7:0]}, 32'h96);
        chk("ext_tx", {24'h0, peer_rx}, 32'h69);
        port_sc_dir <= 1'b0;
    endtask
    task automatic t_abort;
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(4, 0, 0, 0, 1, 0, 1));
        // same select code rewritten, never a new one
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(4, 0, 0, 0, 1, 0, 1));
        rc();
        chk("restart", {30'h0, rd[10], rd[8]}, 32'h2);
        apb(ssm_pkg::OFS_CTRL, 1'b1, ctl(4, 0, 0, 1, 0, 0, 1));
        rc();
        chk("abort", {29'h0, rd[11:9]}, 32'h1);
        apb(ssm_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
        // Done events from earlier transfers are still pending
        chk("ev_abort", rd & 32'h3, 32'h3);
    endtask
    task automatic t_unmapped;
        apb(8'hfc, 1'b0, 32'h0);
        chk("bad_rd", {rd[30:0], err}, 32'h1);
        apb(8'hfc, 1'b1, 32'hffffffff);
        chk("bad_wr", {31'h0, err}, 32'h1);
        rc();
        chk("ok_err", {31'h0, err}, 32'h0);
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rate();
        t_irq();
        t_mode1();
        t_ext();
        t_abort();
        t_unmapped();
        complete_run();
    end
endmodule
